/* File: src/nv_access_top.sv */
// Register access unit for the nonvolatile data array
// What this block does
// - Core reaches the array only indirectly through four register locations.
// - Data byte register carries transfers; location register selects the cell.
// - Array holds 128 bytes, or 256 bytes in the larger variant.
// - Larger variant: top address bit picks the upper 128 locations.
// - Single-byte reads and single-byte writes of addressed cells.
// - Each byte write erases the cell, then programs the new value.
// - Writes are timed internally; their length is variable.
// - Under code protection the core still reads and writes normally.
// - Under code protection the external programmer is refused.
// - Unlock location has no storage; it only takes unlock writes.
// - Read-start loads the data byte from the addressed cell.
// - Write-start stays set until the write ends; software polls it.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module nv_access_top
   import nv_access_pkg::*;
#(
   parameter int unsigned ADDR_BITS = 7,
   parameter int unsigned WRITE_TIME_NS = WRITE_TIME_DEFAULT_NS
) (
   // Clock and resets
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic POR_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [APB_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Code protection level
   input wire logic CODE_PROTECT,
   // External programmer port
   input wire logic PROG_REQ,
   input wire logic PROG_WRITE,
   input wire logic [7:0] PROG_ADDR,
   input wire logic [7:0] PROG_WDATA,
   output logic [7:0] PROG_RDATA,
   output logic PROG_ACK,
   output logic PROG_DENIED
);
   localparam int unsigned WRITE_CYCLES =
      (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] LOC_MASK = 8'((1 << ADDR_BITS) - 1);

   nv_array_if #(.ADDR_BITS(ADDR_BITS)) arr_bus ();

   logic [7:0] byte_r;
   logic [7:0] loc_r;
   logic permit_r;
   logic wr_r;
   logic fault_r;
   logic prog_owner_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic [7:0] prog_rdata_r;
   logic prog_ack_r;
   logic prog_denied_r;

   logic [7:0] reg_index;
   logic [7:0] wbyte;
   logic aligned;
   logic mapped;
   logic setup_phase;
   logic access_done;
   logic wr_go;
   logic wr_byte;
   logic wr_loc;
   logic wr_ctl;
   logic wr_unl;
   logic core_rd_go;
   logic core_wr_req;
   logic core_start;
   logic armed;
   logic prog_rd_ok;
   logic prog_wr_ok;
   logic prog_refuse;
   logic [31:0] read_mux;

   // ==========================================================
   // APB decode
   assign reg_index = PADDR[9:2];
   assign wbyte = PWDATA[7:0];
   assign aligned = (PADDR[11:10] == 2'b00) && (PADDR[1:0] == 2'b00);
   assign mapped = aligned && (reg_index == IDX_BYTE ||
                               reg_index == IDX_LOCATION ||
                               reg_index == IDX_CONTROL ||
                               reg_index == IDX_UNLOCK);
   assign setup_phase = PSEL && !PENABLE;
   assign access_done = PSEL && PENABLE;
   assign wr_go = access_done && PWRITE && mapped;
   assign wr_byte = wr_go && reg_index == IDX_BYTE;
   assign wr_loc = wr_go && reg_index == IDX_LOCATION;
   assign wr_ctl = wr_go && reg_index == IDX_CONTROL;
   assign wr_unl = wr_go && reg_index == IDX_UNLOCK;
   assign PREADY = 1'b1;
   assign PRDATA = prdata_r;
   assign PSLVERR = pslverr_r;

   // ==========================================================
   // Core access requests
   assign core_rd_go = wr_ctl && wbyte[CTL_READ_BIT];
   assign core_wr_req = wr_ctl && wbyte[CTL_WRITE_BIT];
   assign core_start = core_wr_req && permit_r && armed &&
                       !arr_bus.busy;

   nv_unlock_gate nv_unlock_gate_inst (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .wr_go(wr_go),
      .to_unlock(wr_unl),
      .wbyte(wbyte),
      .armed(armed)
   );

   // ==========================================================
   // Programmer arbitration; the core always wins a tie
   assign prog_rd_ok = PROG_REQ && !PROG_WRITE && !CODE_PROTECT;
   assign prog_wr_ok = PROG_REQ && PROG_WRITE && !CODE_PROTECT &&
                       !arr_bus.busy && !core_start;
   assign prog_refuse = PROG_REQ && !prog_rd_ok && !prog_wr_ok;

   // ==========================================================
   // Array connection
   assign arr_bus.rd_addr = loc_r[ADDR_BITS-1:0];
   assign arr_bus.prog_rd_addr = PROG_ADDR[ADDR_BITS-1:0];
   assign arr_bus.wr_start = core_start || prog_wr_ok;
   assign arr_bus.wr_addr = core_start ? loc_r[ADDR_BITS-1:0] :
                            PROG_ADDR[ADDR_BITS-1:0];
   assign arr_bus.wr_data = core_start ? byte_r : PROG_WDATA;

   nv_array #(
      .ADDR_BITS(ADDR_BITS),
      .WRITE_CYCLES(WRITE_CYCLES)
   ) nv_array_inst (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .port(arr_bus.store)
   );

   // ==========================================================
   // Data byte and location registers keep their value over warm reset
   always_ff @(posedge CLK_SYS) begin
      if (!POR_N) begin
         byte_r <= BYTE_RESET;
      end else if (core_rd_go) begin
         byte_r <= arr_bus.rd_data;
      end else if (wr_byte) begin
         byte_r <= wbyte;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!POR_N) begin
         loc_r <= BYTE_RESET;
      end else if (wr_loc) begin
         loc_r <= wbyte & LOC_MASK;
      end
   end

   // ==========================================================
   // Control register
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         permit_r <= 1'b0;
      end else if (wr_ctl) begin
         permit_r <= wbyte[CTL_PERMIT_BIT];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         wr_r <= 1'b0;
      end else if (core_start) begin
         wr_r <= 1'b1;
      end else if (wr_r && !arr_bus.busy) begin
         wr_r <= 1'b0;
      end
   end

   // Fault is set by a warm reset that cuts a write short
   always_ff @(posedge CLK_SYS) begin
      if (!POR_N) begin
         fault_r <= 1'b0;
      end else if (!RESET_N) begin
         if (arr_bus.busy) begin
            fault_r <= 1'b1;
         end
      end else if (wr_ctl) begin
         fault_r <= fault_r & wbyte[CTL_FAULT_BIT];
      end
   end

   // ==========================================================
   // Programmer answers
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         prog_owner_r <= 1'b0;
      end else if (prog_wr_ok) begin
         prog_owner_r <= 1'b1;
      end else if (prog_owner_r && !arr_bus.busy) begin
         prog_owner_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         prog_ack_r <= 1'b0;
         prog_denied_r <= 1'b0;
      end else begin
         prog_ack_r <= prog_rd_ok || (prog_owner_r && !arr_bus.busy);
         prog_denied_r <= prog_refuse;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         prog_rdata_r <= BYTE_RESET;
      end else if (prog_rd_ok) begin
         prog_rdata_r <= arr_bus.prog_rd_data;
      end
   end

   assign PROG_RDATA = prog_rdata_r;
   assign PROG_ACK = prog_ack_r;
   assign PROG_DENIED = prog_denied_r;

   // ==========================================================
   // APB read data, captured in the setup cycle
   always_comb begin
      read_mux = WORD_ZERO;
      if (aligned) begin
         unique case (reg_index)
            IDX_BYTE: read_mux[7:0] = byte_r;
            IDX_LOCATION: read_mux[7:0] = loc_r;
            IDX_CONTROL: begin
               read_mux[CTL_WRITE_BIT] = wr_r;
               read_mux[CTL_PERMIT_BIT] = permit_r;
               read_mux[CTL_FAULT_BIT] = fault_r;
            end
            default: read_mux = WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         prdata_r <= WORD_ZERO;
         pslverr_r <= 1'b0;
      end else if (setup_phase) begin
         prdata_r <= PWRITE ? WORD_ZERO : read_mux;
         pslverr_r <= !mapped;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   start_unlocked_a: assert property (
      $rose(arr_bus.busy) && !$past(prog_wr_ok)
      |-> $past(armed && permit_r && core_wr_req))
      else $error("write started without unlock and permit");
   no_permit_a: assert property (
      core_wr_req && !permit_r && !wr_r && !arr_bus.busy && !prog_wr_ok
      |=> !wr_r && !arr_bus.busy)
      else $error("write started without permit");
   wr_clears_a: assert property (wr_r && !arr_bus.busy |=> !wr_r)
      else $error("write-start bit not cleared at completion");
   wr_follows_a: assert property (core_start |=> wr_r && arr_bus.busy)
      else $error("core write did not start");
   read_loads_a: assert property (
      core_rd_go |=> byte_r == $past(arr_bus.rd_data))
      else $error("read-start did not load the data byte");
   prog_refused_a: assert property (
      PROG_REQ && CODE_PROTECT |=> PROG_DENIED && !PROG_ACK)
      else $error("programmer access under protection");
   unlock_empty_a: assert property (
      setup_phase && !PWRITE && aligned && reg_index == IDX_UNLOCK
      |=> PRDATA == WORD_ZERO)
      else $error("unlock location returned data");
   loc_width_a: assert property ((loc_r & ~LOC_MASK) == 8'h00)
      else $error("unimplemented address bit held");
   fault_reset_a: assert property (
      @(posedge CLK_SYS) disable iff (!POR_N)
      !RESET_N && arr_bus.busy |=> fault_r)
      else $error("interrupted write left no fault");

   core_write_c: cover property (core_start ##1 wr_r [*8] ##[1:600] !wr_r);
   core_read_c: cover property (core_rd_go && CODE_PROTECT);
   prog_denied_c: cover property (PROG_REQ && CODE_PROTECT);
   prog_write_c: cover property (prog_wr_ok ##[1:600] PROG_ACK);

endmodule
`default_nettype wire

/* File: src/nv_access_pkg.sv */
// Shared constants and types of the nonvolatile data array access unit
package nv_access_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned WRITE_TIME_DEFAULT_NS = 4000;
   localparam int unsigned JITTER_BITS = 4;

   // ==========================================================
   // Register indices; byte address is index times four
   localparam logic [7:0] IDX_BYTE = 8'h9a;
   localparam logic [7:0] IDX_LOCATION = 8'h9b;
   localparam logic [7:0] IDX_CONTROL = 8'h9c;
   localparam logic [7:0] IDX_UNLOCK = 8'h9d;
   localparam int unsigned APB_ADDR_W = 12;

   // ==========================================================
   // Control register fields
   localparam int CTL_READ_BIT = 0;
   localparam int CTL_WRITE_BIT = 1;
   localparam int CTL_PERMIT_BIT = 2;
   localparam int CTL_FAULT_BIT = 3;

   // ==========================================================
   // Data values and reset values
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'haa;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] LFSR_SEED = 8'h01;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ==========================================================
   // State types
   typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED}
      unlock_state_t;
   typedef enum logic [1:0] {ARR_IDLE, ARR_ERASE, ARR_PROGRAM} array_state_t;

endpackage

/* File: src/nv_array_if.sv */
// Connection between the access unit and its array store
`timescale 1ns/10ps
`default_nettype none
interface nv_array_if #(
   parameter int unsigned ADDR_BITS = 7
);
   logic [ADDR_BITS-1:0] rd_addr;
   logic [7:0] rd_data;
   logic [ADDR_BITS-1:0] prog_rd_addr;
   logic [7:0] prog_rd_data;
   logic wr_start;
   logic [ADDR_BITS-1:0] wr_addr;
   logic [7:0] wr_data;
   logic busy;

   modport ctrl (
      output rd_addr, prog_rd_addr, wr_start, wr_addr, wr_data,
      input rd_data, prog_rd_data, busy
   );
   modport store (
      input rd_addr, prog_rd_addr, wr_start, wr_addr, wr_data,
      output rd_data, prog_rd_data, busy
   );
endinterface
`default_nettype wire

/* File: src/nv_unlock_gate.sv */
// Tracker of the two-step unlock sequence that arms a write start
`timescale 1ns/10ps
`default_nettype none
module nv_unlock_gate
   import nv_access_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus write strobes
   input wire logic wr_go,
   input wire logic to_unlock,
   input wire logic [7:0] wbyte,
   // Armed for the next write
   output logic armed
);
   unlock_state_t state_r;

   // ==========================================================
   // Sequence: first value, second value, then the very next write
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= UNL_IDLE;
      end else if (wr_go) begin
         if (to_unlock && wbyte == UNLOCK_FIRST) begin
            state_r <= UNL_GOT_FIRST;
         end else if (to_unlock && wbyte == UNLOCK_SECOND &&
                      state_r == UNL_GOT_FIRST) begin
            state_r <= UNL_ARMED;
         end else begin
            state_r <= UNL_IDLE;
         end
      end
   end

   assign armed = (state_r == UNL_ARMED);

endmodule
`default_nettype wire

/* File: src/nv_array.sv */
// Byte array store with self-timed erase-then-program writes
`timescale 1ns/10ps
`default_nettype none
module nv_array
   import nv_access_pkg::*;
#(
   parameter int unsigned ADDR_BITS = 7,
   parameter int unsigned WRITE_CYCLES = 500
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Access side
   nv_array_if.store port
);
   localparam int unsigned DEPTH = 1 << ADDR_BITS;
   localparam int unsigned ERASE_CYCLES = WRITE_CYCLES / 2;
   localparam int unsigned PROG_CYCLES = WRITE_CYCLES - ERASE_CYCLES;
   localparam int MAX_BUSY = WRITE_CYCLES + (1 << JITTER_BITS) + 2;
   localparam int unsigned CW = $clog2(MAX_BUSY) + 1;

   logic [7:0] mem [DEPTH];
   array_state_t state_r;
   logic [CW-1:0] count_r;
   logic [7:0] lfsr_r;
   logic [ADDR_BITS-1:0] addr_r;
   logic [7:0] data_r;
   logic start;
   logic timer_done;

   assign start = port.wr_start && state_r == ARR_IDLE;
   assign timer_done = (count_r == '0);
   assign port.busy = (state_r != ARR_IDLE);
   assign port.rd_data = mem[port.rd_addr];
   assign port.prog_rd_data = mem[port.prog_rd_addr];

   // ==========================================================
   // Free-running jitter source: write length is not fixed
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lfsr_r <= LFSR_SEED;
      end else begin
         lfsr_r <= {lfsr_r[6:0],
                    lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      end
   end

   // ==========================================================
   // Write timer; reset aborts the write in progress
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= ARR_IDLE;
         count_r <= '0;
         addr_r <= '0;
         data_r <= BYTE_RESET;
      end else begin
         unique case (state_r)
            ARR_IDLE: begin
               if (start) begin
                  state_r <= ARR_ERASE;
                  count_r <= CW'(ERASE_CYCLES - 1) +
                             CW'(lfsr_r[JITTER_BITS-1:0]);
                  addr_r <= port.wr_addr;
                  data_r <= port.wr_data;
               end
            end
            ARR_ERASE: begin
               if (timer_done) begin
                  state_r <= ARR_PROGRAM;
                  count_r <= CW'(PROG_CYCLES - 1);
               end else begin
                  count_r <= count_r - CW'(1);
               end
            end
            ARR_PROGRAM: begin
               if (timer_done) begin
                  state_r <= ARR_IDLE;
               end else begin
                  count_r <= count_r - CW'(1);
               end
            end
            default: begin
               state_r <= ARR_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Cell array: erased at start, new value at the end of programming
   always_ff @(posedge clk) begin
      if (start) begin
         mem[port.wr_addr] <= ERASED_BYTE;
      end else if (state_r == ARR_PROGRAM && timer_done && reset_n) begin
         mem[addr_r] <= data_r;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   erase_first_a: assert property (start |=> mem[addr_r] == ERASED_BYTE)
      else $error("location not erased at write start");
   busy_min_a: assert property ($rose(port.busy) |-> port.busy [*8])
      else $error("write finished too early");
   busy_bound_a: assert property (
      $rose(port.busy) |-> ##[1:MAX_BUSY] !port.busy)
      else $error("write did not finish in time");

endmodule
`default_nettype wire

/* File: sim/data_eeprom_access_port_tb.sv */
// Self-checking bench of the nonvolatile array access unit
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_access_port_tb
   import nv_access_pkg::*;
();
   // ==========================================================
   // Stimulus and observation
   localparam logic [11:0] A_BYTE = {2'b00, IDX_BYTE, 2'b00};
   localparam logic [11:0] A_LOC = {2'b00, IDX_LOCATION, 2'b00};
   localparam logic [11:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
   localparam logic [11:0] A_UNL = {2'b00, IDX_UNLOCK, 2'b00};
   localparam logic [11:0] A_BAD = 12'h100;
   localparam logic [7:0] C_READ = 8'h01 << CTL_READ_BIT;
   localparam logic [7:0] C_START = 8'h01 << CTL_WRITE_BIT;
   localparam logic [7:0] C_PERMIT = 8'h01 << CTL_PERMIT_BIT;
   localparam logic [7:0] C_FAULT = 8'h01 << CTL_FAULT_BIT;
   logic clk_sys = 1'b0;
   logic reset_n, por_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic code_protect, prog_req, prog_write, prog_ack, prog_denied;
   logic [7:0] prog_addr, prog_wdata, prog_rdata;
   int errors = 0;
   int comparisons = 0;

   always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

   nv_access_top #(.ADDR_BITS(7), .WRITE_TIME_NS(80)) nv_access_top_inst (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .POR_N(por_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CODE_PROTECT(code_protect),
      .PROG_REQ(prog_req), .PROG_WRITE(prog_write),
      .PROG_ADDR(prog_addr), .PROG_WDATA(prog_wdata),
      .PROG_RDATA(prog_rdata), .PROG_ACK(prog_ack),
      .PROG_DENIED(prog_denied)
   );

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 32'h1, {31'h0, pready});
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] v;
      logic e;
      apb(1'b1, a, {24'h0, d}, v, e);
      chk("write slave error", 32'h0, {31'h0, e});
   endtask

   task automatic rdc(input logic [11:0] a, input logic [7:0] x,
                      input logic xe, input string what);
      logic [31:0] v;
      logic e;
      apb(1'b0, a, WORD_ZERO, v, e);
      chk(what, {24'h0, x}, v);
      chk({what, " slave error"}, {31'h0, xe}, {31'h0, e});
   endtask

   task automatic core_start(input logic [7:0] loc, input logic [7:0] d);
      wr(A_LOC, loc);
      wr(A_BYTE, d);
      wr(A_CTL, C_PERMIT);
      wr(A_UNL, UNLOCK_FIRST);
      wr(A_UNL, UNLOCK_SECOND);
      wr(A_CTL, C_PERMIT | C_START);
   endtask

   task automatic wait_done;
      logic [31:0] v;
      logic e;
      int n;
      n = 0;
      v = 32'h2;
      while (v[CTL_WRITE_BIT] !== 1'b0 && n < 100) begin
         apb(1'b0, A_CTL, WORD_ZERO, v, e);
         n++;
      end
      chk("start clears", 32'h0, {31'h0, v[CTL_WRITE_BIT]});
   endtask

   task automatic core_write(input logic [7:0] loc, input logic [7:0] d);
      core_start(loc, d);
      rdc(A_CTL, C_PERMIT | C_START, 1'b0, "start while busy");
      wait_done();
   endtask

   task automatic core_read(input logic [7:0] loc, input logic [7:0] x,
                            input string what);
      wr(A_LOC, loc);
      wr(A_BYTE, 8'h00);
      wr(A_CTL, C_READ);
      rdc(A_BYTE, x, 1'b0, what);
   endtask

   task automatic prog(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic xa,
                       input logic xd);
      @(posedge clk_sys);
      prog_req <= 1'b1;
      prog_write <= w;
      prog_addr <= a;
      prog_wdata <= d;
      @(posedge clk_sys);
      prog_req <= 1'b0;
      @(posedge clk_sys);
      chk("programmer ack", {31'h0, xa}, {31'h0, prog_ack});
      chk("programmer denied", {31'h0, xd}, {31'h0, prog_denied});
   endtask

   task automatic prog_write_wait(input logic [7:0] a, input logic [7:0] d);
      int n;
      prog(1'b1, a, d, 1'b0, 1'b0);
      n = 0;
      while (prog_ack !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      chk("programmer write ack", 32'h1, {31'h0, prog_ack});
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_after_reset;
      logic [31:0] v;
      logic e;
      rdc(A_BYTE, BYTE_RESET, 1'b0, "byte after reset");
      rdc(A_LOC, BYTE_RESET, 1'b0, "location after reset");
      rdc(A_CTL, 8'h00, 1'b0, "control after reset");
      rdc(A_BAD, 8'h00, 1'b1, "unmapped read");
      apb(1'b1, A_BAD, 32'h0000_00ff, v, e);
      chk("unmapped write error", 32'h1, {31'h0, e});
      wr(A_UNL, UNLOCK_FIRST);
      rdc(A_UNL, 8'h00, 1'b0, "unlock readback");
      $display("test after_reset done");
   endtask

   task automatic t_read_write;
      core_write(8'h00, 8'h3c);
      core_write(8'h7f, 8'h5a);
      core_read(8'h00, 8'h3c, "cell 00");
      core_read(8'h7f, 8'h5a, "cell 7f");
      core_write(8'h00, 8'h3c);
      core_read(8'h00, 8'h3c, "refreshed cell");
      core_write(8'h10, 8'hf0);
      core_write(8'h10, 8'h0f);
      core_read(8'h10, 8'h0f, "rewritten cell");
      wr(A_LOC, 8'hff);
      rdc(A_LOC, 8'h7f, 1'b0, "location top bit");
      $display("test read_write done");
   endtask

   task automatic t_refusals;
      core_write(8'h20, 8'h11);
      wr(A_BYTE, 8'h22);
      wr(A_CTL, 8'h00);
      wr(A_UNL, UNLOCK_FIRST);
      wr(A_UNL, UNLOCK_SECOND);
      wr(A_CTL, C_START);
      rdc(A_CTL, 8'h00, 1'b0, "start without permit");
      wr(A_CTL, C_PERMIT);
      wr(A_UNL, UNLOCK_FIRST);
      wr(A_BYTE, 8'h22);
      wr(A_UNL, UNLOCK_SECOND);
      wr(A_CTL, C_PERMIT | C_START);
      rdc(A_CTL, C_PERMIT, 1'b0, "broken unlock");
      wr(A_UNL, UNLOCK_SECOND);
      wr(A_UNL, UNLOCK_FIRST);
      wr(A_CTL, C_PERMIT | C_START);
      rdc(A_CTL, C_PERMIT, 1'b0, "reversed unlock");
      core_read(8'h20, 8'h11, "cell after refusals");
      $display("test refusals done");
   endtask

   task automatic t_protect;
      @(posedge clk_sys);
      code_protect <= 1'b1;
      prog(1'b0, 8'h20, 8'h00, 1'b0, 1'b1);
      prog(1'b1, 8'h20, 8'h99, 1'b0, 1'b1);
      core_write(8'h21, 8'h77);
      core_read(8'h21, 8'h77, "protected core read");
      core_read(8'h20, 8'h11, "cell kept from programmer");
      @(posedge clk_sys);
      code_protect <= 1'b0;
      prog(1'b0, 8'h21, 8'h00, 1'b1, 1'b0);
      chk("programmer data", 32'h77, {24'h0, prog_rdata});
      prog_write_wait(8'h22, 8'h5e);
      core_read(8'h22, 8'h5e, "programmer write");
      core_start(8'h23, 8'h66);
      prog(1'b1, 8'h23, 8'h00, 1'b0, 1'b1);
      wait_done();
      core_read(8'h23, 8'h66, "write beside programmer");
      $display("test protect done");
   endtask

   task automatic t_reset_abort;
      core_start(8'h30, 8'h44);
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      rdc(A_CTL, C_FAULT, 1'b0, "fault after abort");
      rdc(A_LOC, 8'h30, 1'b0, "location kept");
      rdc(A_BYTE, 8'h44, 1'b0, "byte kept");
      wr(A_CTL, C_FAULT);
      rdc(A_CTL, C_FAULT, 1'b0, "fault kept by one");
      wr(A_CTL, 8'h00);
      rdc(A_CTL, 8'h00, 1'b0, "fault cleared");
      core_read(8'h30, ERASED_BYTE, "aborted cell");
      $display("test reset_abort done");
   endtask

   // ==========================================================
   // Run control
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      reset_n = 1'b0;
      por_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = WORD_ZERO;
      code_protect = 1'b0;
      prog_req = 1'b0;
      prog_write = 1'b0;
      prog_addr = 8'h00;
      prog_wdata = 8'h00;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      por_n <= 1'b1;
      t_after_reset();
      t_read_write();
      t_refusals();
      t_protect();
      t_reset_abort();
      final_report();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      $display("MISMATCH watchdog expected finish seen timeout");
      final_report();
   end
endmodule
`default_nettype wire
